// [src/temp_monitor_defs.svh]
// register map, reset values, field positions and timing figures of the monitor
// assumes a 100 MHz mclk; long counts are turned into top-level parameters
// Summary of operation
// R01: normal mode converts back to back, 240 ms
// R02: each result lands in temperature register
// R03: first conversion after power-up takes 6 ms
// R04: defaults trip critical at 147, limit 64
// R05: conversion timing internal, serial clock only transfers
// R06: results compared with critical, high, low limits
// R07: alarm polarity and mode set by config
// R08: code 01 runs one conversion then shuts down
// R09: host waits 240 ms before one-shot read
// R10: rewriting one-shot code starts a fresh conversion
// R11: code 10 converts 60 ms, idles 940 ms
// R12: interrupt mode: any read releases both alarms
// R13: one-shot comparator: mode write releases limit alarm
// R14: one-shot comparator: mode write releases critical alarm
// R15: code 11 shuts down, code 00 resumes
// R16: leaving shutdown waits 1 ms then converts; the code waits only when code 00 is written, codes 01 and 10 convert at once
// R17: last result stays readable during shutdown
// R18: alarms need queued count of consecutive faults
// R19: a clean result zeroes the fault counter
// R20: 13-bit format, low three bits are flags
// R21: config bit 7 selects 16-bit format
// R22: host reads temperature as two bytes
// R23: fault queue codes 00..11 mean one..four
// R24: config bit 4 zero selects interrupt behaviour
// R25: 13-bit compares ignore the three flag bits
`ifndef TEMP_MONITOR_DEFS_SVH
`define TEMP_MONITOR_DEFS_SVH

`define ADDR_STATUS 3'h0
`define ADDR_CONFIG 3'h1
`define ADDR_TEMP 3'h2
`define ADDR_IDENT 3'h3
`define ADDR_CRIT 3'h4
`define ADDR_HYST 3'h5
`define ADDR_HIGH 3'h6
`define ADDR_LOW 3'h7

`define RST_STATUS 8'h80
`define RST_CONFIG 8'h00
`define RST_TEMP 16'h0000
`define RST_CRIT 16'h4980
`define RST_HYST 8'h05
`define RST_HIGH 16'h2000
`define RST_LOW 16'h0500
// arbitrary identification value
`define IDENT_VALUE 8'hA5

`define CFG_QUEUE_LSB 0
`define CFG_QUEUE_MSB 1
`define CFG_CT_POL 2
`define CFG_INT_POL 3
`define CFG_CMP_MODE 4
`define CFG_MODE_LSB 5
`define CFG_MODE_MSB 6
`define CFG_RES16 7

`define MCLK_HZ 100000000
`define CYC_PER_MS (`MCLK_HZ / 1000)
`define CONV_MS 240
`define FAST_MS 6
`define SPS_CONV_MS 60
`define SPS_REST_MS 940
`define WAKE_MS 1

`endif

// [src/temp_monitor_pkg.sv]
// types shared by the monitor and its serial port engine
// assumes nothing beyond the defs header
package temp_monitor_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_ONESHOT = 2'b01,
		MODE_SPS = 2'b10,
		MODE_SHUTDOWN = 2'b11
	} op_mode_t;

	typedef enum logic [1:0] {
		ST_SHUT = 2'b00,
		ST_WAKE = 2'b01,
		ST_CONV = 2'b10,
		ST_REST = 2'b11
	} seq_state_t;
endpackage

// [src/serial_port_engine.sv]
// serial port shifter: command byte then 8 or 16 data bits, msb first
// assumes sclk idles high, din sampled on rising, dout changed on falling edge
module serial_port_engine (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_sync_n,
	// pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// register side
	input wire logic wide,
	input wire logic [15:0] rd_word,
	output logic [2:0] addr,
	output logic is_rd,
	output logic cmd_stb,
	output logic wr_stb,
	output logic [15:0] wr_data
);
	import temp_monitor_pkg::*;

	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic sclk_d_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [3:0] cnt_q;
	logic data_ph_q;
	logic load_q;
	logic rise;
	logic fall;
	logic [15:0] rx_d;

	// pin inputs pass two flops; only s2 feeds logic
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			s1_q <= 3'h7;
			s2_q <= 3'h7;
			sclk_d_q <= 1'b1;
		end
		else
		begin
			s1_q <= {sclk, cs_n, din};
			s2_q <= s1_q;
			sclk_d_q <= s2_q[2]; // R05
		end
	end

	assign rise = s2_q[2] & ~sclk_d_q;
	assign fall = ~s2_q[2] & sclk_d_q;
	assign rx_d = {rx_q[14:0], s2_q[0]};

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rx_q <= 16'h0000;
			cnt_q <= 4'h0;
			data_ph_q <= 1'b0;
			addr <= 3'h0;
			is_rd <= 1'b0;
			cmd_stb <= 1'b0;
			wr_stb <= 1'b0;
			wr_data <= 16'h0000;
		end
		else
		begin
			cmd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (s2_q[1])
			begin
				cnt_q <= 4'h0;
				data_ph_q <= 1'b0;
			end
			else if (rise)
			begin
				rx_q <= rx_d;
				cnt_q <= cnt_q + 4'h1;
				if (!data_ph_q && cnt_q == 4'h7)
				begin
					addr <= rx_d[5:3];
					is_rd <= rx_d[6];
					cmd_stb <= 1'b1;
					data_ph_q <= 1'b1;
					cnt_q <= 4'h0;
				end
				else if (data_ph_q && cnt_q == (wide ? 4'hF : 4'h7)) // R22
				begin
					cnt_q <= 4'h0;
					wr_stb <= ~is_rd;
					wr_data <= rx_d;
				end
			end
		end
	end

	// read word loads one cycle after the command, long before the next falling edge
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			load_q <= 1'b0;
			tx_q <= 16'h0000;
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end
		else
		begin
			load_q <= cmd_stb & is_rd;
			dout_oe <= ~s2_q[1];
			if (load_q)
				tx_q <= rd_word;
			else if (fall && data_ph_q && is_rd && !s2_q[1])
			begin
				dout <= tx_q[15];
				tx_q <= {tx_q[14:0], 1'b0};
			end
		end
	end
endmodule

// [src/temp_conversion_limit_monitor.sv]
// conversion sequencer, result register, limit compare, fault queue and alarm pins
// assumes sensor_code is a settled converter word on mclk; alarm pins are open drain
`include "temp_monitor_defs.svh"

module temp_conversion_limit_monitor #(
	parameter int unsigned CONV_CYC = `CONV_MS * `CYC_PER_MS,
	parameter int unsigned FAST_CYC = `FAST_MS * `CYC_PER_MS,
	parameter int unsigned SPS_CONV_CYC = `SPS_CONV_MS * `CYC_PER_MS,
	parameter int unsigned SPS_REST_CYC = `SPS_REST_MS * `CYC_PER_MS,
	parameter int unsigned WAKE_CYC = `WAKE_MS * `CYC_PER_MS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial port pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// converter
	input wire logic [15:0] sensor_code,
	output logic conv_busy,
	// alarm pins, open drain
	output logic ct_o,
	output logic ct_oe,
	output logic int_o,
	output logic int_oe
);
	import temp_monitor_pkg::*;

	logic rst_s1_q;
	logic rst_sync_n;

	logic [7:0] cfg_q;
	logic [7:0] hyst_q;
	logic [15:0] crit_q;
	logic [15:0] high_q;
	logic [15:0] low_q;
	logic [15:0] temp_q;
	logic rdy_n_q;
	logic flag_crit_q;
	logic flag_high_q;
	logic flag_low_q;
	logic crit_act_q;
	logic lim_act_q;
	logic [2:0] fcnt_q;

	seq_state_t st_q;
	logic [31:0] tmr_q;
	logic [31:0] len_q;
	logic first_q;

	logic [2:0] addr;
	logic is_rd;
	logic cmd_stb;
	logic wr_stb;
	logic [15:0] wr_data;
	logic wide;
	logic [15:0] rd_word;

	logic rd_stb;
	logic cfg_wr;
	op_mode_t cur_mode;
	op_mode_t new_mode;
	logic done;
	logic [15:0] mask;
	logic [15:0] code;
	logic [16:0] code_x;
	logic [16:0] last_x;
	logic [16:0] crit_x;
	logic [16:0] high_x;
	logic [16:0] low_x;
	logic [16:0] hyst_x;
	logic over_crit;
	logic over_high;
	logic under_low;
	logic fault;
	logic trip;
	logic new_crit_ok;
	logic new_high_ok;
	logic new_low_ok;
	logic last_crit_ok;
	logic last_lim_ok;
	logic oneshot_cmp_wr;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_sync_n <= rst_s1_q;
		end
	end

	serial_port_engine u_port (
		.mclk(mclk),
		.rst_sync_n(rst_sync_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.dout(dout),
		.dout_oe(dout_oe),
		.wide(wide),
		.rd_word(rd_word),
		.addr(addr),
		.is_rd(is_rd),
		.cmd_stb(cmd_stb),
		.wr_stb(wr_stb),
		.wr_data(wr_data)
	);

	assign wide = (addr == `ADDR_TEMP) || (addr == `ADDR_CRIT) ||
		(addr == `ADDR_HIGH) || (addr == `ADDR_LOW); // R22
	assign rd_stb = cmd_stb & is_rd;
	assign cfg_wr = wr_stb && (addr == `ADDR_CONFIG);
	assign cur_mode = op_mode_t'(cfg_q[`CFG_MODE_MSB:`CFG_MODE_LSB]);
	assign new_mode = op_mode_t'(wr_data[`CFG_MODE_MSB:`CFG_MODE_LSB]);

	// read mux, 8-bit registers left aligned in the shift word
	always_comb
	begin
		rd_word = 16'h0000;
		unique case (addr)
			`ADDR_STATUS: rd_word = {rdy_n_q, flag_crit_q, flag_high_q, flag_low_q, 12'h000};
			`ADDR_CONFIG: rd_word = {cfg_q, 8'h00};
			`ADDR_TEMP: rd_word = cfg_q[`CFG_RES16] ? temp_q :
				{temp_q[15:3], flag_crit_q, flag_high_q, flag_low_q}; // R17 R20 R21
			`ADDR_IDENT: rd_word = {`IDENT_VALUE, 8'h00};
			`ADDR_CRIT: rd_word = crit_q;
			`ADDR_HYST: rd_word = {hyst_q, 8'h00};
			`ADDR_HIGH: rd_word = high_q;
			`ADDR_LOW: rd_word = low_q;
		endcase
	end

	// writable registers
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			cfg_q <= `RST_CONFIG; // R21 R23 R24
			hyst_q <= `RST_HYST;
			crit_q <= `RST_CRIT; // R04
			high_q <= `RST_HIGH; // R04
			low_q <= `RST_LOW;
		end
		else if (wr_stb)
		begin
			unique case (addr)
				`ADDR_CONFIG: cfg_q <= wr_data[7:0]; // R07
				`ADDR_HYST: hyst_q <= wr_data[7:0];
				`ADDR_CRIT: crit_q <= wr_data;
				`ADDR_HIGH: high_q <= wr_data;
				`ADDR_LOW: low_q <= wr_data;
				default: ;
			endcase
		end
	end

	// conversion sequencer on the internal clock only
	assign done = (st_q == ST_CONV) && (tmr_q == len_q - 32'd1) && !cfg_wr;

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			st_q <= ST_CONV;
			tmr_q <= 32'd0;
			len_q <= 32'(FAST_CYC); // R03
			first_q <= 1'b1;
		end
		else if (cfg_wr)
		begin
			tmr_q <= 32'd0;
			unique case (new_mode)
				MODE_SHUTDOWN: st_q <= ST_SHUT; // R15
				MODE_ONESHOT:
				begin
					st_q <= ST_CONV; // R08 R10
					len_q <= 32'(CONV_CYC);
				end
				MODE_SPS:
					if (cur_mode != MODE_SPS || st_q == ST_SHUT)
					begin
						st_q <= ST_CONV; // R11
						len_q <= 32'(SPS_CONV_CYC);
					end
					else
						tmr_q <= tmr_q;
				MODE_NORMAL:
					if (st_q == ST_SHUT)
						st_q <= ST_WAKE; // R15 R16
					else if (cur_mode != MODE_NORMAL && st_q == ST_REST)
					begin
						st_q <= ST_CONV;
						len_q <= 32'(CONV_CYC);
					end
					else
						tmr_q <= tmr_q;
			endcase
		end
		else
		begin
			tmr_q <= tmr_q + 32'd1;
			unique case (st_q)
				ST_SHUT: tmr_q <= 32'd0;
				ST_WAKE:
					if (tmr_q == 32'(WAKE_CYC) - 32'd1)
					begin
						st_q <= ST_CONV; // R16
						len_q <= 32'(CONV_CYC);
						tmr_q <= 32'd0;
					end
				ST_CONV:
					if (done)
					begin
						first_q <= 1'b0;
						tmr_q <= 32'd0;
						unique case (cur_mode)
							MODE_NORMAL: len_q <= 32'(CONV_CYC); // R01
							MODE_ONESHOT: st_q <= ST_SHUT; // R08
							MODE_SPS: st_q <= ST_REST; // R11
							MODE_SHUTDOWN: st_q <= ST_SHUT;
						endcase
					end
				ST_REST:
					if (tmr_q == 32'(SPS_REST_CYC) - 32'd1)
					begin
						st_q <= ST_CONV; // R11
						len_q <= 32'(SPS_CONV_CYC);
						tmr_q <= 32'd0;
					end
			endcase
		end
	end

	// compare in 16-bit scale; 13-bit drops the flag bits
	assign mask = cfg_q[`CFG_RES16] ? 16'hFFFF : 16'hFFF8; // R25
	assign code = sensor_code & mask;
	assign code_x = {code[15], code};
	assign last_x = {temp_q[15], temp_q};
	assign crit_x = {crit_q[15], crit_q & mask};
	assign high_x = {high_q[15], high_q & mask};
	assign low_x = {low_q[15], low_q & mask};
	// hysteresis counts whole degrees: 128 codes each
	assign hyst_x = {6'h00, hyst_q[3:0], 7'h00};

	assign over_crit = $signed(code_x) > $signed(crit_x); // R06
	assign over_high = $signed(code_x) > $signed(high_x); // R06
	assign under_low = $signed(code_x) < $signed(low_x); // R06
	assign fault = over_crit | over_high | under_low;
	assign trip = fault && (fcnt_q >= {1'b0, cfg_q[`CFG_QUEUE_MSB:`CFG_QUEUE_LSB]}); // R18 R23

	assign new_crit_ok = $signed(code_x) < $signed(crit_x - hyst_x);
	assign new_high_ok = $signed(code_x) < $signed(high_x - hyst_x);
	assign new_low_ok = $signed(code_x) > $signed(low_x + hyst_x);
	assign last_crit_ok = $signed(last_x) < $signed(crit_x - hyst_x);
	assign last_lim_ok = ($signed(last_x) < $signed(high_x - hyst_x)) &&
		($signed(last_x) > $signed(low_x + hyst_x));
	assign oneshot_cmp_wr = cfg_wr && cfg_q[`CFG_CMP_MODE] && cur_mode == MODE_ONESHOT;

	// result register, held through shutdown
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			temp_q <= `RST_TEMP;
		else if (done)
			temp_q <= code; // R02 R17
	end

	// consecutive fault counter, saturates at four
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			fcnt_q <= 3'h0;
		else if (done)
		begin
			if (!fault)
				fcnt_q <= 3'h0; // R19
			else if (fcnt_q != 3'h4)
				fcnt_q <= fcnt_q + 3'h1; // R18
		end
	end

	// ready flag: conversion end wins over a same-cycle release
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rdy_n_q <= 1'(`RST_STATUS >> 7);
		else if (done)
			rdy_n_q <= 1'b0;
		else if ((rd_stb && addr == `ADDR_TEMP) ||
			(cfg_wr && (cur_mode == MODE_ONESHOT || cur_mode == MODE_SPS)))
			rdy_n_q <= 1'b1;
	end

	// status flags: set on a tripping result, cleared by status read or hysteresis
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			flag_crit_q <= 1'b0;
			flag_high_q <= 1'b0;
			flag_low_q <= 1'b0;
		end
		else
		begin
			if (done && trip && over_crit)
				flag_crit_q <= 1'b1;
			else if ((rd_stb && addr == `ADDR_STATUS) || (done && new_crit_ok))
				flag_crit_q <= 1'b0;
			if (done && trip && over_high)
				flag_high_q <= 1'b1;
			else if ((rd_stb && addr == `ADDR_STATUS) || (done && new_high_ok))
				flag_high_q <= 1'b0;
			if (done && trip && under_low)
				flag_low_q <= 1'b1;
			else if ((rd_stb && addr == `ADDR_STATUS) || (done && new_low_ok))
				flag_low_q <= 1'b0;
		end
	end

	// alarm state; a trip in the same cycle beats any release
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			crit_act_q <= 1'b0;
			lim_act_q <= 1'b0;
		end
		else if (cfg_q[`CFG_CMP_MODE])
		begin
			if (done && trip && over_crit)
				crit_act_q <= 1'b1; // R06 R18
			else if ((done && new_crit_ok) || (oneshot_cmp_wr && last_crit_ok))
				crit_act_q <= 1'b0; // R14
			if (done && trip && (over_high || under_low))
				lim_act_q <= 1'b1; // R06 R18
			else if ((done && new_high_ok && new_low_ok) || (oneshot_cmp_wr && last_lim_ok))
				lim_act_q <= 1'b0; // R13
		end
		else
		begin
			if (done && trip && over_crit)
				crit_act_q <= 1'b1; // R24
			else if (rd_stb)
				crit_act_q <= 1'b0; // R12
			if (done && trip && (over_high || under_low))
				lim_act_q <= 1'b1; // R24
			else if (rd_stb)
				lim_act_q <= 1'b0; // R12
		end
	end

	// open drain: pull low when the wanted level is low; active-high relies on the pull-up
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ct_o <= 1'b0;
			ct_oe <= 1'b0;
			int_o <= 1'b0;
			int_oe <= 1'b0;
			conv_busy <= 1'b0;
		end
		else
		begin
			ct_o <= 1'b0;
			int_o <= 1'b0;
			ct_oe <= crit_act_q ^ cfg_q[`CFG_CT_POL]; // R04 R07
			int_oe <= lim_act_q ^ cfg_q[`CFG_INT_POL]; // R04 R07
			conv_busy <= (st_q == ST_CONV);
		end
	end
endmodule

// [tb/temp_monitor_checker.sv]
// pin-level assertions for the conversion and limit monitor
// bound to the top module; sees only its ports
module temp_monitor_checker #(
	parameter int unsigned FAST_CYC = 50
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial port
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dout,
	input wire logic dout_oe,
	// converter and alarms
	input wire logic conv_busy,
	input wire logic ct_o,
	input wire logic ct_oe,
	input wire logic int_o,
	input wire logic int_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] up_q;

	// cycles since reset release, saturating
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			up_q <= 16'h0000;
		else if (up_q != 16'hFFFF)
			up_q <= up_q + 16'h0001;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ct_open_drain: assert property (!ct_o)
		else $error("critical pin driven high");
	a_int_open_drain: assert property (!int_o)
		else $error("limit pin driven high");
	a_fast_start: assert property ($rose(rst_n) |-> ##[1:4] conv_busy)
		else $error("no conversion after reset");
	a_fast_hold: assert property ((up_q >= 16'h0005 && up_q < FAST_CYC) |-> conv_busy)
		else $error("first conversion cut short");
	a_quiet_start: assert property ((up_q < FAST_CYC) |-> (!ct_oe && !int_oe))
		else $error("alarm before any result");
	a_select_drive: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
		else $error("data out not enabled");
	a_select_release: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
		else $error("data out not released");
	// data may only move a few cycles after a serial clock fall
	a_dout_after_fall: assert property ((!cs_n && dout_oe && $past(dout_oe) && $changed(dout))
		|-> !($past(sclk, 2) && $past(sclk, 3) && $past(sclk, 4) && $past(sclk, 5)))
		else $error("data out moved without clock fall");
endmodule

bind temp_conversion_limit_monitor temp_monitor_checker #(.FAST_CYC(FAST_CYC)) checker_inst (
	.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
	.conv_busy(conv_busy), .ct_o(ct_o), .ct_oe(ct_oe), .int_o(int_o), .int_oe(int_oe));

// [tb/host_spi_model.sv]
// host serial master driving the monitor's port
// assumes sclk idles high; bits change on falls and are sampled on rises
module host_spi_model (
	// serial pins
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe,
	// read results
	output logic [15:0] rd_data,
	output logic rd_done
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rd_data = 16'h0000;
		rd_done = 1'b0;
	end

	// 80 ns link clock, still between frames
	task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int nb);
		logic [23:0] sh;
		logic [15:0] rd;
		logic b;
		sh = (nb == 16) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
		rd = 16'h0000;
		b = 1'b0;
		#13 cs_n = 1'b0;
		#40;
		for (int i = 0; i < 8 + nb; i++)
		begin
			sclk = 1'b0;
			din = sh[23 - i];
			#40 sclk = 1'b1;
			// undriven line reads as the inverse, never a stale bit
			b = dout_oe ? dout : ~b;
			rd = {rd[14:0], b};
			#40;
		end
		cs_n = 1'b1;
		din = ~din;
		#60;
		if (cmd[6])
		begin
			rd_data = (nb == 16) ? rd : {8'h00, rd[7:0]};
			rd_done = 1'b1;
			#10 rd_done = 1'b0;
		end
	endtask
endmodule

// [tb/temp_conversion_limit_monitor_tb.sv]
// self-checking bench for the conversion and limit monitor
// assumes host_spi_model and the bound checker; short cycle counts
module temp_conversion_limit_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned CONV = 1000;
	localparam int unsigned SREST = 100;
	localparam logic [2:0] DADR[4] = '{3'h1, 3'h4, 3'h6, 3'h7};
	localparam logic [15:0] DEF[4] = '{16'h0000, 16'h4980, 16'h2000, 16'h0500};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] sensor_code = 16'h0C80;
	logic probe_stb = 1'b0;
	logic [31:0] rng = 32'h8E368FEA;
	logic [18:0] notes[$];
	logic [18:0] cur;
	int miscompares = 0;
	int check_count = 0;
	wire sclk, cs_n, din, dout, dout_oe, conv_busy, ct_oe, int_oe, rd_done;
	wire [15:0] rd_data;

	always #5 mclk = ~mclk;

	temp_conversion_limit_monitor #(.CONV_CYC(CONV), .FAST_CYC(50), .SPS_CONV_CYC(60),
		.SPS_REST_CYC(SREST), .WAKE_CYC(20)) temp_conversion_limit_monitor_inst (
		.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .sensor_code(sensor_code), .conv_busy(conv_busy), .ct_o(),
		.ct_oe(ct_oe), .int_o(), .int_oe(int_oe));

	host_spi_model host_spi_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .rd_data(rd_data), .rd_done(rd_done));

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// above low plus hysteresis, below high minus hysteresis
	function automatic logic [15:0] cool();
		return {13'h0F1 + 13'(xs() % 32'hBF), 3'(xs())};
	endfunction
	// above high limit, below critical
	function automatic logic [15:0] hot();
		return {13'h401 + 13'(xs() % 32'h52E), 3'(xs())};
	endfunction

	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// oldest note against whatever just appeared
	always @(posedge rd_done or posedge probe_stb)
	begin
		if (notes.size() == 0)
			check("unexpected result", 18'h00000, 18'h3FFFF);
		else
		begin
			cur = notes.pop_front();
			if (cur[18])
				check("pins and busy", cur[17:0], {ct_oe, int_oe, 15'h0000, conv_busy});
			else
				check("read word and pins", cur[17:0], {ct_oe, int_oe, rd_data});
		end
	end

	task automatic rd(input logic [2:0] a, input int nb, input logic [15:0] w,
		input logic [1:0] pins);
		notes.push_back({1'b0, pins, w});
		host_spi_model_inst.frame({2'b01, a, 3'b000}, 16'h0000, nb);
	endtask
	task automatic wr(input logic [2:0] a, input int nb, input logic [15:0] w);
		host_spi_model_inst.frame({2'b00, a, 3'b000}, w, nb);
	endtask
	task automatic probe(input logic [1:0] pins, input logic busy);
		notes.push_back({1'b1, pins, 15'h0000, busy});
		@(posedge mclk);
		#1 probe_stb = 1'b1;
		@(posedge mclk);
		#1 probe_stb = 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wait_lvl(input logic lvl);
		int i;
		for (i = 0; i < 3000 && conv_busy !== lvl; i++)
			@(posedge mclk);
		if (i == 3000)
		begin
			miscompares++;
			give_verdict();
		end
	endtask
	// only where conversions stop between results
	task automatic wait_end();
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		cyc(4);
	endtask

	initial
	begin
		#1000000;
		miscompares++;
		give_verdict();
	end

	initial
	begin
		logic [15:0] v;
		sensor_code = {13'h190, 3'(xs())};
		cyc(12);
		rst_n = 1'b1;
		cyc(70);
		rd(3'h2, 16, {sensor_code[15:3], 3'b000}, 2'b00);
		for (int i = 0; i < 4; i++)
			rd(DADR[i], (i == 0) ? 8 : 16, DEF[i], 2'b00);
		wr(3'h2, 16, 16'hFFFF);
		v = cool();
		sensor_code = v;
		cyc(CONV + 20);
		rd(3'h2, 16, {v[15:3], 3'b000}, 2'b00);
		wr(3'h1, 8, 16'h0060);
		cyc(CONV + 20);
		probe(2'b00, 1'b0);
		sensor_code = cool();
		rd(3'h2, 16, {v[15:3], 3'b000}, 2'b00);
		v = sensor_code;
		wr(3'h1, 8, 16'h0000);
		probe(2'b00, 1'b0);
		cyc(20);
		probe(2'b00, 1'b1);
		cyc(CONV);
		rd(3'h2, 16, {v[15:3], 3'b000}, 2'b00);
		sensor_code = 16'h2008;
		wr(3'h1, 8, 16'h0020);
		wait_end();
		probe(2'b01, 1'b0);
		rd(3'h2, 16, 16'h200A, 2'b00);
		sensor_code = 16'h4988;
		wr(3'h1, 8, 16'h0020);
		wait_end();
		probe(2'b11, 1'b0);
		rd(3'h1, 8, 16'h0020, 2'b00);
		sensor_code = cool();
		rd(3'h2, 16, 16'h498E, 2'b00);
		sensor_code = 16'h4988;
		wr(3'h1, 8, 16'h0030);
		wait_end();
		probe(2'b11, 1'b0);
		sensor_code = cool();
		wr(3'h1, 8, 16'h0030);
		wait_end();
		probe(2'b00, 1'b0);
		for (int q = 0; q < 4; q++)
		begin
			wr(3'h1, 8, 16'h0050 | 16'(q));
			sensor_code = cool();
			wait_end();
			wait_end();
			probe(2'b00, 1'b0);
			for (int k = 0; k < 2 * q + 2; k++)
			begin
				sensor_code = (k == q) ? cool() : hot();
				wait_end();
				probe({1'b0, k == 2 * q + 1}, 1'b0);
			end
		end
		cyc(SREST - 20);
		probe(2'b01, 1'b0);
		cyc(30);
		probe(2'b01, 1'b1);
		sensor_code = cool();
		wait_end();
		wait_end();
		sensor_code = 16'h2007;
		wr(3'h1, 8, 16'h0020);
		wait_end();
		probe(2'b00, 1'b0);
		sensor_code = 16'h2001;
		wr(3'h1, 8, 16'h00A0);
		wait_end();
		probe(2'b01, 1'b0);
		rd(3'h2, 16, 16'h2001, 2'b00);
		wr(3'h1, 8, 16'h006C);
		probe(2'b11, 1'b0);
		check("pending notes", 18'(notes.size()), 18'h00000);
		give_verdict();
	end
endmodule
